// >>> rtl/srd_pkg.sv
// Behaviour
// - Sample sync input on sampling clock rise
// - Assert on pin rise or bit 0-to-1
// - Host selects pin or register source
// - Reset divider every assertion unless masked
// - NCO and LMFC reset from third assertion
// - Third or later accepted assertion aligns multiframe boundary
// - Also reset decimation filters
// - Divider mask blocks divider reset
// - NCO/link mask blocks NCO and LMFC
// - Programmable delay on sync input path
// - Buffer powerdown stops pin assertion detection
package srd_pkg;

  // ***********************************************************
  // Widths and constants
  // ***********************************************************
  localparam int unsigned DLY_W   = 4;          // Delay tap select width
  localparam int unsigned DLY_N   = 16;         // Number of delay taps
  localparam int unsigned CNT_W   = 2;          // Assertion counter width
  localparam logic [1:0]  CNT_RST = 2'h0;       // Counter reset value
  localparam logic [1:0]  CNT_SAT = 2'h3;       // Counter saturation value
  localparam logic [1:0]  CNT_ONE = 2'h1;       // Counter increment
  localparam real         DLL_US  = 40.0;       // Settling time, us
  localparam real         CLK_MHZ = 100.0;      // Clock rate, MHz

  // Source selection
  typedef enum logic {
    SRD_SRC_PIN = 1'b0,
    SRD_SRC_REG = 1'b1
  } srd_src_t;

  // Configuration bits from the host
  typedef struct packed {
    srd_src_t         src_sel;                   // Pin or register source
    logic             sw_sync_assert_bit;        // Software assert bit
    logic             divider_sync_mask;         // Blocks divider resets
    logic             nco_link_sync_mask;        // Blocks NCO/LMFC resets
    logic             sync_buffer_powerdown;     // Powers input buffer down
    logic [DLY_W-1:0] dly_sel;                   // Input delay tap
  } srd_cfg_t;

  // Reset pulses to the targets
  typedef struct packed {
    logic div_rst;                               // Interleave clock divider
    logic dec_rst;                               // Decimation filters
    logic nco_rst;                               // NCO phase accumulators
    logic lmfc_rst;                              // LMFC counter / boundary
  } srd_rst_t;

endpackage : srd_pkg

// >>> rtl/srd_delay.sv
`timescale 1ns/1ps
`default_nettype none
// Programmable tap delay line for the sync input
module srd_delay (
  input  wire logic                    i_ref_clk,
  input  wire logic                    i_rst_n,
  input  wire logic                    i_din,
  input  wire logic [srd_pkg::DLY_W-1:0] i_sel,
  output logic                         o_dout
);
  import srd_pkg::*;

  logic [DLY_N-1:0] taps_q;                      // Shift chain of taps

  // ***********************************************************
  // Tap chain, one flop per tap via generate
  // ***********************************************************
  genvar g;
  generate
    for (g = 0; g < DLY_N; g++) begin : g_tap
      always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          taps_q[g] <= 1'b0;
        end else begin
          taps_q[g] <= (g == 0) ? i_din : taps_q[(g == 0) ? 0 : g-1];
        end
      end
    end
  endgenerate

  // Selected tap, registered so the output is a flop
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_dout <= 1'b0;
    end else begin
      o_dout <= taps_q[i_sel];
    end
  end

endmodule // srd_delay
`default_nettype wire

// >>> rtl/srd_edge.sv
`timescale 1ns/1ps
`default_nettype none
// Rising edge detector; one-cycle pulse on 0-to-1
module srd_edge (
  input  wire logic i_ref_clk,
  input  wire logic i_rst_n,
  input  wire logic i_lvl,
  output logic      o_rise
);
  logic prev_q;                                  // Last seen level

  // Previous level; reset to 0 so a high level at start counts as an edge
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= i_lvl;
    end
  end

  // Combinational pulse, registered by the caller
  assign o_rise = i_lvl & ~prev_q;

endmodule // srd_edge
`default_nettype wire

// >>> rtl/srd_top.sv
`timescale 1ns/1ps
`default_nettype none
// Sync reference capture and reset distribution
module srd_top (
  input  wire logic              i_ref_clk,
  input  wire logic              i_reset_n,
  input  wire logic              i_sync_pin,
  input  wire srd_pkg::srd_cfg_t i_cfg,
  output srd_pkg::srd_rst_t      o_rst,
  output logic [1:0]             o_assert_cnt,
  output logic                   o_sync_seen
);
  import srd_pkg::*;

  // ***********************************************************
  // Overview
  // ***********************************************************
  // A sync assertion comes from the pin or from the software
  // assert bit; the source select decides which one is heard.
  // Pin path: two sync flops, the tap delay, the buffer gate and an
  // edge detector. A pin rise shows as reset pulses on the fifth
  // edge after it with tap zero, one edge later per tap step.
  // Register path: two sync flops and an edge detector, so a 0-to-1
  // write shows as reset pulses on the third edge after it.
  // Divider and decimation resets follow every unmasked assertion;
  // NCO and LMFC resets only from the third assertion onward.
  // Every accepted assertion is counted, masked or not, and the count
  // stops at three so it can never wrap back into the ignore window.
  // The mask bits are read without synchronisers to keep the pulse
  // latency fixed; the host must hold them steady around an assertion.
  // A powered-down buffer hides the pin but not the register source.
  // Outputs are all registered, so the reset targets see clean pulses.

  // ***********************************************************
  // Reset release
  // ***********************************************************
  logic [1:0] rst_sync_q;                        // Release synchroniser
  logic       rst_n;                             // Internal reset

  // Assert asynchronously, release after two edges
  // Release is synchronous so no flop leaves reset a cycle ahead
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // ***********************************************************
  // Input capture
  // ***********************************************************
  logic pin_s1_q;                                // First sync flop
  logic pin_s2_q;                                // Second sync flop
  logic sw_s1_q;                                 // Soft bit, treated as async
  logic sw_s2_q;

  // Two flops on the pin, clocked by the sampling clock rise
  // The first flop may go metastable; only the second is read
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_q <= 1'b0;
      pin_s2_q <= 1'b0;
    end else begin
      pin_s1_q <= i_sync_pin;
      pin_s2_q <= pin_s1_q;
    end
  end

  // Config bits may come from the host interface clock, so synchronise
  // Only the software bit goes through here; its edge detector reads sw_s2_q
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sw_s1_q <= 1'b0;
      sw_s2_q <= 1'b0;
    end else begin
      sw_s1_q <= i_cfg.sw_sync_assert_bit;
      sw_s2_q <= sw_s1_q;
    end
  end

  // ***********************************************************
  // Delay, buffer gating, source selection
  // ***********************************************************
  logic pin_dly;                                 // Delayed pin level
  logic pin_buf;                                 // After buffer powerdown
  logic pin_rise;
  logic sw_rise;
  logic sync_evt;                                // Accepted assertion

  // Tap delay trims skew between the sync pin and the clock
  // Tap zero still costs two cycles; each step adds one more
  srd_delay u_delay (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (rst_n),
    .i_din     (pin_s2_q),
    .i_sel     (i_cfg.dly_sel),
    .o_dout    (pin_dly)
  );

  // A powered-down buffer reads as a steady low
  assign pin_buf = pin_dly & ~i_cfg.sync_buffer_powerdown;

  // Pin edge detector; a pin already high at reset release counts as a rise
  srd_edge u_pin_edge (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (rst_n),
    .i_lvl     (pin_buf),
    .o_rise    (pin_rise)
  );

  // Register edge detector; only a 0-to-1 of the bit counts
  srd_edge u_sw_edge (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (rst_n),
    .i_lvl     (sw_s2_q),
    .o_rise    (sw_rise)
  );

  // Only the selected source can assert; the other is ignored
  assign sync_evt = (i_cfg.src_sel == SRD_SRC_REG) ? sw_rise : pin_rise;

  // ***********************************************************
  // Assertion counter
  // ***********************************************************
  logic [CNT_W-1:0] cnt_q;                       // Saturating count
  logic             late_ok;                     // Third or later

  // Saturates so it never wraps back into the ignore window
  // Masked assertions are counted too, so masking never shifts
  // which assertion counts as the third
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= CNT_RST;
    end else if (sync_evt && cnt_q != CNT_SAT) begin
      cnt_q <= cnt_q + CNT_ONE;
    end
  end

  // Current event is the third or later when two already counted
  // The counter still holds the old count in the event cycle
  assign late_ok = (cnt_q >= (CNT_SAT - CNT_ONE));

  // ***********************************************************
  // Reset pulse outputs
  // ***********************************************************
  // One-cycle pulses; the masks gate the outputs, not the count
  // Decimation filters share the divider's mask
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_rst <= '0;
    end else begin
      o_rst.div_rst  <= sync_evt & ~i_cfg.divider_sync_mask;
      o_rst.dec_rst  <= sync_evt & ~i_cfg.divider_sync_mask;
      o_rst.nco_rst  <= sync_evt & late_ok & ~i_cfg.nco_link_sync_mask;
      o_rst.lmfc_rst <= sync_evt & late_ok & ~i_cfg.nco_link_sync_mask;
    end
  end

  // Status count: follows the internal counter edge for edge
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_assert_cnt <= CNT_RST;
    end else begin
      o_assert_cnt <= (sync_evt && cnt_q != CNT_SAT) ? cnt_q + CNT_ONE : cnt_q;
    end
  end

  // Sticky seen flag: set by any accepted assertion, cleared by reset only
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_sync_seen <= 1'b0;
    end else begin
      o_sync_seen <= o_sync_seen | sync_evt;
    end
  end

  // ***********************************************************
  // Assertions
  // ***********************************************************
  // Divider reset follows every unmasked assertion
  property p_div;
    @(posedge i_ref_clk) disable iff (!rst_n)
      (sync_evt && !i_cfg.divider_sync_mask) |=> o_rst.div_rst;
  endproperty
  a_div: assert property (p_div) else $error("divider reset missing");

  // A set divider mask keeps the divider phase untouched
  property p_divmask;
    @(posedge i_ref_clk) disable iff (!rst_n)
      i_cfg.divider_sync_mask |=> !o_rst.div_rst;
  endproperty
  a_divmask: assert property (p_divmask) else $error("divider reset while masked");

  // First two assertions never reach the NCO or LMFC
  property p_early;
    @(posedge i_ref_clk) disable iff (!rst_n)
      (cnt_q < 2'h2) |=> !o_rst.nco_rst && !o_rst.lmfc_rst;
  endproperty
  a_early: assert property (p_early) else $error("NCO reset before third");

  // Once saturated, every unmasked assertion realigns the multiframe
  property p_late;
    @(posedge i_ref_clk) disable iff (!rst_n)
      (sync_evt && cnt_q == CNT_SAT && !i_cfg.nco_link_sync_mask) |=> o_rst.nco_rst && o_rst.lmfc_rst;
  endproperty
  a_late: assert property (p_late) else $error("late NCO reset missing");

  // A set NCO/link mask blocks the NCO reset
  property p_ncomask;
    @(posedge i_ref_clk) disable iff (!rst_n)
      i_cfg.nco_link_sync_mask |=> !o_rst.nco_rst;
  endproperty
  a_ncomask: assert property (p_ncomask) else $error("NCO reset while masked");

  // The count never leaves three once there
  property p_sat;
    @(posedge i_ref_clk) disable iff (!rst_n)
      (cnt_q == CNT_SAT) |=> (cnt_q == CNT_SAT);
  endproperty
  a_sat: assert property (p_sat) else $error("counter left saturation");

  // Each assertion below saturation steps the count by one
  property p_cnt;
    @(posedge i_ref_clk) disable iff (!rst_n)
      (sync_evt && cnt_q != CNT_SAT) |=> (cnt_q == $past(cnt_q) + CNT_ONE);
  endproperty
  a_cnt: assert property (p_cnt) else $error("counter did not step");

  // A powered-down buffer lets no pin assertion through
  property p_pdn;
    @(posedge i_ref_clk) disable iff (!rst_n)
      (i_cfg.sync_buffer_powerdown && i_cfg.src_sel == SRD_SRC_PIN)[*2] |-> !sync_evt;
  endproperty
  a_pdn: assert property (p_pdn) else $error("edge seen while powered down");

  // Register source: only the software bit can assert
  property p_src;
    @(posedge i_ref_clk) disable iff (!rst_n)
      (i_cfg.src_sel == SRD_SRC_REG && !sw_rise) |-> !sync_evt;
  endproperty
  a_src: assert property (p_src) else $error("pin asserted in register mode");

  // Decimation filters are reset by every assertion the divider mask lets through
  property p_dec;
    @(posedge i_ref_clk) disable iff (!rst_n)
      (sync_evt && !i_cfg.divider_sync_mask) |=> o_rst.dec_rst;
  endproperty
  a_dec: assert property (p_dec) else $error("decimator reset missing");

  // A set NCO/link mask blocks the LMFC reset as well
  property p_lmfcmask;
    @(posedge i_ref_clk) disable iff (!rst_n)
      i_cfg.nco_link_sync_mask |=> !o_rst.lmfc_rst;
  endproperty
  a_lmfcmask: assert property (p_lmfcmask) else $error("LMFC reset while masked");

  // The third assertion is the first to reset the NCO and LMFC
  property p_third;
    @(posedge i_ref_clk) disable iff (!rst_n)
      (sync_evt && cnt_q == (CNT_SAT - CNT_ONE) && !i_cfg.nco_link_sync_mask) |=> o_rst.nco_rst && o_rst.lmfc_rst;
  endproperty
  a_third: assert property (p_third) else $error("third assertion reset missing");

  // No divider reset without an accepted assertion just before it
  property p_divevt;
    @(posedge i_ref_clk) disable iff (!rst_n)
      o_rst.div_rst |-> $past(sync_evt);
  endproperty
  a_divevt: assert property (p_divevt) else $error("divider reset without assertion");

  // NCO reset only after an assertion with two already counted
  property p_ncoevt;
    @(posedge i_ref_clk) disable iff (!rst_n)
      o_rst.nco_rst |-> $past(sync_evt) && ($past(cnt_q) != CNT_RST) && ($past(cnt_q) != CNT_ONE);
  endproperty
  a_ncoevt: assert property (p_ncoevt) else $error("NCO reset inside ignore window");

  // Seen flag stays set until reset
  property p_seen;
    @(posedge i_ref_clk) disable iff (!rst_n)
      o_sync_seen |=> o_sync_seen;
  endproperty
  a_seen: assert property (p_seen) else $error("seen flag dropped");

  // A held software bit yields one assertion only
  property p_swonce;
    @(posedge i_ref_clk) disable iff (!rst_n)
      sw_rise |=> !sw_rise;
  endproperty
  a_swonce: assert property (p_swonce) else $error("software bit asserted twice");

  // Status count steps together with the internal counter
  property p_cntout;
    @(posedge i_ref_clk) disable iff (!rst_n)
      (sync_evt && cnt_q != CNT_SAT) |=> (o_assert_cnt == $past(cnt_q) + CNT_ONE);
  endproperty
  a_cntout: assert property (p_cntout) else $error("status count did not step");

  // ***********************************************************
  // Cover points
  // ***********************************************************
  // Early assertion, third assertion, register source, masked event, powered-down pin
  c_first: cover property (@(posedge i_ref_clk) disable iff (!rst_n) o_rst.div_rst && !o_rst.nco_rst);
  c_third: cover property (@(posedge i_ref_clk) disable iff (!rst_n) o_rst.nco_rst);
  c_sw:    cover property (@(posedge i_ref_clk) disable iff (!rst_n) sw_rise && i_cfg.src_sel == SRD_SRC_REG);
  c_mask:  cover property (@(posedge i_ref_clk) disable iff (!rst_n) sync_evt && i_cfg.nco_link_sync_mask);
  c_pdn:   cover property (@(posedge i_ref_clk) disable iff (!rst_n) pin_dly && i_cfg.sync_buffer_powerdown);

endmodule // srd_top
`default_nettype wire

// >>> tb/srd_partner.sv
`timescale 1ns/1ps
`default_nettype none
// ***********************************************************
// Timing generator stand-in: short sync pulses on request
// ***********************************************************
module srd_partner (
  input  wire logic i_ref_clk,
  input  wire logic i_fire,
  output logic      o_sync_pin
);
  logic [1:0] len_q; // High cycles left

  // Pin stays low except for one pulse per bench request
  // Pulses are spaced by the bench well apart; masks set meanwhile
  // Pin returns low after each pulse, so sync stops when idle
  always @(posedge i_ref_clk) begin
    if (i_fire) begin
      len_q <= 2'h3;
    end else if (len_q != 2'h0) begin
      len_q <= len_q - 2'h1;
    end
  end
  assign o_sync_pin = (len_q != 2'h0);
  initial len_q = 2'h0;
endmodule // srd_partner
`default_nettype wire

// >>> tb/test_srd_top.sv
`timescale 1ns/1ps
`default_nettype none
module test_srd_top;
  import srd_pkg::*;
  logic i_ref_clk = 1'b0;                // Sampling clock
  logic i_reset_n = 1'b0;                // Async reset
  logic fire = 1'b0;                     // Partner pulse request
  logic pin;                             // Sync pin
  srd_cfg_t cfg = '0;                    // Host config
  srd_rst_t o_rst;                       // Reset pulses
  logic [1:0] o_assert_cnt;              // Assertion count
  logic o_sync_seen;                     // Sticky flag
  int mismatches = 0;                    // Failed compares
  int cmp_count = 0;                     // All compares
  int cnt = 0;                           // Model count
  int lat;                               // Cycles to first pulse
  logic sticky = 1'b0;                   // Model sticky flag

  always #5 i_ref_clk = ~i_ref_clk;

  srd_partner u_part (.i_ref_clk(i_ref_clk), .i_fire(fire), .o_sync_pin(pin));
  srd_top dut (.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_sync_pin(pin), .i_cfg(cfg),
               .o_rst(o_rst), .o_assert_cnt(o_assert_cnt), .o_sync_seen(o_sync_seen));

  // ***********************************************************
  // Compare and report
  // ***********************************************************
  task automatic chk_rst(input logic [3:0] e, input logic [3:0] g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR o_rst expected %b seen %b", e, g);
    end
  endtask
  task automatic chk_val(input string n, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %0d seen %0d", n, e, g);
    end
  endtask
  task automatic finish_test();
    $display("Compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // One trigger from pin or bit, scan a window, compare with the model
  task automatic evt(input logic use_pin, input logic taken);
    logic [3:0] seen;
    logic [3:0] e;
    logic d;
    logic n;
    seen = 4'h0;
    lat = -1;
    d = ~cfg.divider_sync_mask;
    n = (cnt >= 2) && !cfg.nco_link_sync_mask;
    e = taken ? {d, d, n, n} : 4'h0;
    if (use_pin) fire = 1'b1;
    else cfg.sw_sync_assert_bit = 1'b1;
    for (int i = 0; i < 40; i++) begin
      @(posedge i_ref_clk);
      #1;
      fire = 1'b0;
      if (o_rst != 4'h0 && lat < 0) lat = i;
      seen = seen | o_rst;
    end
    if (taken) begin
      cnt = (cnt < 3) ? cnt + 1 : 3;
      sticky = 1'b1;
    end
    chk_rst(e, seen);
    chk_val("o_assert_cnt", cnt, o_assert_cnt);
    chk_val("o_sync_seen", sticky, o_sync_seen);
    cfg.sw_sync_assert_bit = 1'b0;
    repeat (6) @(posedge i_ref_clk);
    #1;
  endtask

  task automatic do_reset();
    i_reset_n = 1'b0;
    repeat (4) @(posedge i_ref_clk);
    #1;
    i_reset_n = 1'b1;
    repeat (4) @(posedge i_ref_clk);
    #1;
    cnt = 0;
    sticky = 1'b0;
  endtask

  initial begin
    #1ms;
    mismatches++;
    finish_test();
  end

  initial begin
    int l0;
    void'($urandom(32'hcba33acf));
    do_reset();
    cfg.src_sel = SRD_SRC_REG;
    for (int k = 0; k < 6; k++) begin
      cfg.divider_sync_mask = $urandom % 2;
      cfg.nco_link_sync_mask = $urandom % 2;
      evt(1'b0, 1'b1);
    end
    evt(1'b1, 1'b0);
    $display("Register source test done");
    cfg.src_sel = SRD_SRC_PIN;
    cfg.divider_sync_mask = 1'b0;
    evt(1'b0, 1'b0);
    cfg.dly_sel = 4'h0;
    evt(1'b1, 1'b1);
    l0 = lat;
    cfg.dly_sel = 4'h1 + ($urandom % 15);
    evt(1'b1, 1'b1);
    chk_val("latency step", cfg.dly_sel, lat - l0);
    $display("Pin source and input delay test done");
    cfg.sync_buffer_powerdown = 1'b1;
    evt(1'b1, 1'b0);
    cfg.sync_buffer_powerdown = 1'b0;
    $display("Buffer powerdown test done");
    do_reset();
    chk_val("o_assert_cnt", 0, o_assert_cnt);
    cfg.nco_link_sync_mask = 1'b0;
    for (int k = 0; k < 3; k++) evt(1'b1, 1'b1);
    $display("Reset in mid run test done");
    finish_test();
  end
endmodule // test_srd_top
`default_nettype wire
